// File: llc_pkg.sv
// Constants, field layout and register map of the logic cell cluster
// Summary of operation
// - Each logic cell has a four-input table realising any four-variable function.
// - Each cell register can act as a D, T, JK or SR flip-flop.
// - A cell register has data, clock, clock-enable and clear inputs.
// - For combinational use the table result bypasses the register to the outputs.
// - Three outputs per cell, each selecting table result or register output.
// - Packed cells, with table and register unrelated, ignore the synchronous load.
// - Feedback lets a register output drive its own cell's table input.
// - A cell can drive registered and unregistered table results together.
// - Registers cascade through a chain path forming a shift register.
// - Normal mode: four inputs feed the table; one is carry-in or fourth input.
// - Arithmetic mode: full adder with carry chain, feedback and packing still work.
// - The carry chain leaves the last cell toward the next cluster.
// - Sixteen cells; the register chain feeds each register to the next.
// - Two clocks, two enables, two clears, one sync clear, one sync load.
// - At most four control signals may come from non-global sources; more still take effect and only set a status bit.
// - Sync clear acts on every register, sync load on every unpacked one, at its next clock edge.
// - Each cluster clock is paired with its own clock enable.
// - Capturing on both edges of one clock consumes both cluster clocks.
// - A low clock enable gates its cluster clock; registers hold.
// - Control signals are picked from six row clock lines or local routing.
// - Only asynchronous clear, from two lines; preset by inverting input and output.
// - Enabled device-wide low reset clears all registers and overrides everything.
package llc_pkg;
    localparam int LLC_CELLS = 16;
    localparam int LLC_ADDR_W = 12;
    localparam int LLC_ROW_CLOCKS = 6;
    localparam int LLC_CTRLS = 8;
    localparam int LLC_MAX_NONGLOBAL = 4;
    // Register map
    localparam logic [11:0] OFS_CELL_CFG = 12'h000;
    localparam logic [11:0] OFS_CTRL_SRC = 12'h040;
    localparam logic [11:0] OFS_CTRL_MODE = 12'h044;
    localparam logic [11:0] OFS_STATUS = 12'h048;
    // Cell configuration word
    localparam int F_MASK = 0;
    localparam int F_FFTYPE = 16;
    localparam int F_OSEL = 18;
    localparam int F_CLKSEL = 21;
    localparam int F_CLRSEL = 22;
    localparam int F_FB = 24;
    localparam int F_ARITH = 25;
    localparam int F_CIN = 26;
    localparam int F_CHAIN = 27;
    localparam int F_PACK = 28;
    localparam int F_INV = 29;
    localparam int CELL_CFG_W = 30;
    localparam logic [1:0] FF_D = 2'h0;
    localparam logic [1:0] FF_T = 2'h1;
    localparam logic [1:0] FF_JK = 2'h2;
    localparam logic [1:0] FF_SR = 2'h3;
    // Control signal slots, three source bits each
    localparam int C_CLK1 = 0;
    localparam int C_CLK2 = 1;
    localparam int C_ENA1 = 2;
    localparam int C_ENA2 = 3;
    localparam int C_CLR1 = 4;
    localparam int C_CLR2 = 5;
    localparam int C_SCLR = 6;
    localparam int C_SLOAD = 7;
    localparam int CTRL_SRC_W = 24;
    localparam logic [2:0] SRC_LOCAL = 3'h6;
    localparam logic [2:0] SRC_UNUSED = 3'h7;
    localparam logic [23:0] CTRL_SRC_RST = 24'hfffff8;
    // Mode register
    localparam int M_CLK1_FALL = 0;
    localparam int M_CLK2_FALL = 1;
    localparam int M_DEVRST_EN = 2;
    localparam int MODE_W = 3;
    localparam logic [2:0] CTRL_MODE_RST = 3'h4;
    // Status word
    localparam int S_Q = 0;
    localparam int S_NONGLOBAL_OVER = 16;
    localparam int S_BOTH_EDGES = 17;
    localparam int S_SLOAD_BLOCKED = 18;
    localparam int S_USED = 19;
endpackage : llc_pkg

// File: llc_cluster.sv
// Sixteen-cell logic cluster with shared control logic and APB configuration
module llc_cluster
    import llc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic device_wide_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [LLC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LLC_ROW_CLOCKS-1:0] row_clock,
    input wire logic [LLC_CTRLS-1:0] local_ctrl,
    input wire logic [4*LLC_CELLS-1:0] cell_data,
    input wire logic carry_in,
    input wire logic chain_in,
    output logic [LLC_CELLS-1:0] route_out_a,
    output logic [LLC_CELLS-1:0] route_out_b,
    output logic [LLC_CELLS-1:0] local_out,
    output logic carry_out,
    output logic chain_out
);

    typedef struct packed {
        logic [LLC_CELLS-1:0][CELL_CFG_W-1:0] cfg;
        logic [CTRL_SRC_W-1:0] src;
        logic [MODE_W-1:0] mode;
        logic [1:0] clk_prev;
        logic [LLC_CELLS-1:0] q;
        logic [31:0] rdata;
    } llc_state_s;

    localparam llc_state_s ST_RST = '{cfg: '0, src: CTRL_SRC_RST,
        mode: CTRL_MODE_RST, clk_prev: 2'h0, q: '0, rdata: 32'h0};

    llc_state_s st;
    llc_state_s next_st;

    logic [LLC_CTRLS-1:0] ctl;
    logic [1:0] clk_ev;
    logic [1:0] ena;
    logic devrst;
    logic sclr_on;
    logic sload_on;
    logic [LLC_CELLS:0] carry;
    logic [LLC_CELLS-1:0] lut_out;
    logic [LLC_CELLS-1:0] q_eff;
    logic [LLC_CELLS-1:0] q_vis;
    logic [LLC_CELLS-1:0] clr_vec;
    logic [LLC_CELLS-1:0] upd;
    logic [LLC_CELLS-1:0] reg_d;
    logic [LLC_CELLS-1:0] chain_src;
    logic [LLC_CELLS-1:0] ff_next;
    logic [3:0] nonglobal_cnt;
    logic [3:0] used_cnt;
    logic both_edges;
    logic sload_blocked;
    logic apb_access;
    logic apb_setup;
    logic sel_cell;
    logic mapped;
    logic [31:0] rd_mux;

    function automatic logic lut4(input logic [15:0] mask,
                                  input logic [3:0] idx);
        return mask[idx];
    endfunction : lut4

    // Unused enables read as high so an unused enable never blocks its clock
    function automatic logic pick_src(input logic [2:0] code,
                                      input logic [5:0] row,
                                      input logic loc,
                                      input logic unused_val);
        logic v;
        v = unused_val;
        if (code < 3'h6) begin
            v = row[code];
        end else if (code == SRC_LOCAL) begin
            v = loc;
        end
        return v;
    endfunction : pick_src

    // Control generation and cluster checks
    always_comb begin
        nonglobal_cnt = 4'h0;
        used_cnt = 4'h0;
        for (int k = 0; k < LLC_CTRLS; k++) begin
            ctl[k] = pick_src(st.src[3*k +: 3], row_clock, local_ctrl[k],
                              (k == C_ENA1) || (k == C_ENA2));
            if (st.src[3*k +: 3] == SRC_LOCAL) begin
                nonglobal_cnt = nonglobal_cnt + 4'h1;
            end
            if (st.src[3*k +: 3] != SRC_UNUSED) begin
                used_cnt = used_cnt + 4'h1;
            end
        end
        clk_ev[0] = st.mode[M_CLK1_FALL] ? (st.clk_prev[0] & ~ctl[C_CLK1])
                                         : (~st.clk_prev[0] & ctl[C_CLK1]);
        clk_ev[1] = st.mode[M_CLK2_FALL] ? (st.clk_prev[1] & ~ctl[C_CLK2])
                                         : (~st.clk_prev[1] & ctl[C_CLK2]);
        ena[0] = ctl[C_ENA1];
        ena[1] = ctl[C_ENA2];
        devrst = st.mode[M_DEVRST_EN] & ~device_wide_reset_n;
        sclr_on = ctl[C_SCLR];
        sload_on = ctl[C_SLOAD];
        // Both edges of one source take both clock slots
        both_edges = (st.src[3*C_CLK1 +: 3] == st.src[3*C_CLK2 +: 3])
                     && (st.src[3*C_CLK1 +: 3] != SRC_UNUSED)
                     && (st.mode[M_CLK1_FALL] != st.mode[M_CLK2_FALL]);
        sload_blocked = 1'b0;
        for (int i = 0; i < LLC_CELLS; i++) begin
            if (st.cfg[i][F_PACK] && st.src[3*C_SLOAD +: 3] != SRC_UNUSED) begin
                sload_blocked = 1'b1;
            end
        end
    end

    // Cell datapath
    always_comb begin
        logic [CELL_CFG_W-1:0] c;
        logic a;
        logic b;
        logic in2;
        logic in3;
        logic dv;
        c = '0;
        a = 1'b0;
        b = 1'b0;
        in2 = 1'b0;
        in3 = 1'b0;
        dv = 1'b0;
        carry[0] = carry_in;
        for (int i = 0; i < LLC_CELLS; i++) begin
            c = st.cfg[i];
            clr_vec[i] = ((c[F_CLRSEL +: 2] == 2'h1) & ctl[C_CLR1])
                       | ((c[F_CLRSEL +: 2] == 2'h2) & ctl[C_CLR2]);
            // Clear reaches the outputs in the same cycle, not at the edge
            q_eff[i] = (clr_vec[i] | devrst) ? 1'b0 : st.q[i];
            q_vis[i] = q_eff[i] ^ c[F_INV];
        end
        // Cell 0 takes the chain from the previous cluster
        chain_src = {q_eff[LLC_CELLS-2:0], chain_in};
        for (int i = 0; i < LLC_CELLS; i++) begin
            c = st.cfg[i];
            a = cell_data[4*i];
            b = cell_data[4*i+1];
            in2 = c[F_FB] ? q_vis[i] : cell_data[4*i+2];
            in3 = (c[F_CIN] | c[F_ARITH]) ? carry[i]
                                          : cell_data[4*i+3];
            lut_out[i] = lut4(c[F_MASK +: 16], {in3, in2, b, a});
            if (c[F_ARITH]) begin
                carry[i+1] = (a & b) | (carry[i] & (a ^ b));
            end else begin
                carry[i+1] = carry[i];
            end
            if (c[F_CHAIN]) begin
                reg_d[i] = chain_src[i];
            end else if (c[F_PACK]) begin
                reg_d[i] = cell_data[4*i+3];
            end else begin
                reg_d[i] = lut_out[i];
            end
            dv = reg_d[i] ^ c[F_INV];
            case (c[F_FFTYPE +: 2])
                FF_D: ff_next[i] = dv;
                FF_T: ff_next[i] = st.q[i] ^ dv;
                FF_JK: ff_next[i] = (dv & ~st.q[i]) | (~b & st.q[i]);
                FF_SR: ff_next[i] = b ? 1'b0 : (dv | st.q[i]);
                default: ff_next[i] = dv;
            endcase
            upd[i] = clk_ev[c[F_CLKSEL]] & ena[c[F_CLKSEL]];
            route_out_a[i] = c[F_OSEL] ? q_vis[i] : lut_out[i];
            route_out_b[i] = c[F_OSEL+1] ? q_vis[i] : lut_out[i];
            local_out[i] = c[F_OSEL+2] ? q_vis[i] : lut_out[i];
        end
        carry_out = carry[LLC_CELLS];
        chain_out = q_eff[LLC_CELLS-1];
    end

    // APB decode; no wait states while ce is high, read data latched in the setup cycle
    assign apb_access = psel & penable;
    assign apb_setup = psel & ~penable;
    assign sel_cell = (paddr[LLC_ADDR_W-1:6] == OFS_CELL_CFG[LLC_ADDR_W-1:6]);
    assign mapped = sel_cell || paddr == OFS_CTRL_SRC
                    || paddr == OFS_CTRL_MODE || paddr == OFS_STATUS;
    assign pready = ce;
    assign pslverr = apb_access & ~mapped;
    assign prdata = st.rdata;

    always_comb begin
        rd_mux = 32'h0;
        if (sel_cell) begin
            rd_mux[CELL_CFG_W-1:0] = st.cfg[paddr[5:2]];
        end else if (paddr == OFS_CTRL_SRC) begin
            rd_mux[CTRL_SRC_W-1:0] = st.src;
        end else if (paddr == OFS_CTRL_MODE) begin
            rd_mux[MODE_W-1:0] = st.mode;
        end else if (paddr == OFS_STATUS) begin
            rd_mux[S_Q +: LLC_CELLS] = q_eff;
            rd_mux[S_NONGLOBAL_OVER] =
                nonglobal_cnt > 4'(LLC_MAX_NONGLOBAL);
            rd_mux[S_BOTH_EDGES] = both_edges;
            rd_mux[S_SLOAD_BLOCKED] = sload_blocked;
            rd_mux[S_USED +: 4] = used_cnt;
        end
    end

    always_comb begin
        next_st = st;
        next_st.clk_prev = {ctl[C_CLK2], ctl[C_CLK1]};
        if (apb_setup) begin
            next_st.rdata = rd_mux;
        end
        if (apb_access && pwrite && mapped) begin
            if (sel_cell) begin
                next_st.cfg[paddr[5:2]] = pwdata[CELL_CFG_W-1:0];
            end else if (paddr == OFS_CTRL_SRC) begin
                next_st.src = pwdata[CTRL_SRC_W-1:0];
            end else if (paddr == OFS_CTRL_MODE) begin
                next_st.mode = pwdata[MODE_W-1:0];
            end
        end
        for (int i = 0; i < LLC_CELLS; i++) begin
            if (devrst || clr_vec[i]) begin
                next_st.q[i] = 1'b0;
            end else if (upd[i]) begin
                if (sclr_on) begin
                    next_st.q[i] = 1'b0;
                end else if (sload_on && !st.cfg[i][F_PACK]) begin
                    next_st.q[i] = cell_data[4*i+3]
                                   ^ st.cfg[i][F_INV];
                end else begin
                    next_st.q[i] = ff_next[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= ST_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic quiet0;
    assign quiet0 = !devrst && !clr_vec[0] && !sclr_on && !sload_on;

    a_devrst_clears: assert property (ce && devrst |=> st.q == '0)
        else $error("device reset left a register set");
    a_aclr_zero: assert property (ce && clr_vec[0] && !devrst
        |-> q_eff[0] == 1'b0 ##1 !st.q[0])
        else $error("asynchronous clear did not zero cell 0");
    a_sclr_wins: assert property (ce && upd[0] && sclr_on && sload_on
        && !clr_vec[0] && !devrst |=> st.q[0] == 1'b0)
        else $error("sync load beat sync clear");
    a_hold_disabled: assert property (ce && !upd[0] && !clr_vec[0]
        && !devrst |=> $stable(st.q[0]))
        else $error("register changed without an enabled clock");
    a_chain_shift: assert property (ce && upd[1] && quiet0 && !clr_vec[1]
        && st.cfg[1][F_CHAIN] && st.cfg[1][F_FFTYPE +: 2] == FF_D
        && !st.cfg[1][F_INV] |=> st.q[1] == $past(q_eff[0]))
        else $error("register chain did not shift");
    a_dff_capture: assert property (ce && upd[0] && quiet0
        && st.cfg[0][F_FFTYPE +: 2] == FF_D && !st.cfg[0][F_INV]
        |=> st.q[0] == $past(reg_d[0]))
        else $error("D register missed its data");
    a_toggle_flip: assert property (ce && upd[0] && quiet0 && reg_d[0]
        && st.cfg[0][F_FFTYPE +: 2] == FF_T && !st.cfg[0][F_INV]
        |=> st.q[0] != $past(st.q[0]))
        else $error("T register did not toggle");
    a_pack_noload: assert property (ce && upd[0] && sload_on && !sclr_on
        && !clr_vec[0] && !devrst && st.cfg[0][F_PACK] && !st.cfg[0][F_INV]
        |=> st.q[0] == $past(ff_next[0]))
        else $error("packed cell took the sync load");
    a_bypass_out: assert property (!st.cfg[1][F_OSEL] && st.cfg[1][F_OSEL+1]
        |-> route_out_a[1] == lut_out[1] && route_out_b[1] == q_vis[1])
        else $error("cell outputs not split between table and register");

    c_sclr_edge: cover property (ce && upd[0] && sclr_on ##1 !st.q[0]);
    c_carry_out: cover property (st.cfg[LLC_CELLS-1][F_ARITH] && carry_out);
    c_chain_use: cover property (ce && upd[1] && st.cfg[1][F_CHAIN]);
    c_both_edges: cover property (both_edges ##1 clk_ev[0] ##1 clk_ev[1]);

endmodule : llc_cluster

// File: llc_fabric.sv
// Model of the routing fabric that feeds row clock lines to the cluster
module llc_fabric (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fire,
    output logic [5:0] row_clock,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // One request gives four cycles high, then four low, so a rising
    // event is seen clearly and the line is idle again before the next
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (fire) begin
            cnt <= 4'h8;
        end
    end
    // Only line zero toggles; the other five rest low
    assign row_clock = {5'h00, cnt > 4'h4};
    assign busy = (cnt != 4'h0) || fire;
endmodule : llc_fabric

// File: test_logic_cell_cluster.sv
// Self-checking bench for the logic cell cluster
module test_logic_cell_cluster import llc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Cell 0: mask is AND of four inputs, local output from register,
    // clear from the first clear slot; cell 1: mask is XOR of four inputs
    localparam logic [31:0] CFG0 = 32'h00508000;
    localparam logic [31:0] CFG1 = 32'h00006996;
    logic clk, nrst, ce, device_wide_reset_n, fire, busy, err;
    logic psel, penable, pwrite, pready, pslverr;
    logic [LLC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] row_clock;
    logic [7:0] local_ctrl;
    logic [63:0] cell_data;
    logic [15:0] route_out_a, route_out_b, local_out;
    logic carry_in, chain_in, carry_out, chain_out;
    int failures = 0;
    int checked = 0;
    int cyc = 0;

    llc_cluster u_llc_cluster (.clk(clk), .nrst(nrst), .ce(ce),
        .device_wide_reset_n(device_wide_reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .row_clock(row_clock), .local_ctrl(local_ctrl),
        .cell_data(cell_data), .carry_in(carry_in), .chain_in(chain_in),
        .route_out_a(route_out_a), .route_out_b(route_out_b),
        .local_out(local_out), .carry_out(carry_out), .chain_out(chain_out));
    llc_fabric u_llc_fabric (.clk(clk), .nrst(nrst), .fire(fire),
        .row_clock(row_clock), .busy(busy));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Request stays put until pready is seen high at an edge
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One rising event on row clock zero, then wait for the line to rest
    task automatic tick();
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        repeat (40) begin
            @(negedge clk);
            if (busy !== 1'b1) break;
        end
    endtask : tick

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        device_wide_reset_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        local_ctrl = 8'h04;
        cell_data = '0;
        carry_in = 1'b0;
        chain_in = 1'b0;
        fire = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, OFS_CTRL_SRC, '0);
        chk("ctrl_src reset", 32'h00fffff8, rd);
        apb(1'b0, OFS_CTRL_MODE, '0);
        chk("mode reset", 32'h00000004, rd);
        apb(1'b0, 12'h04c, '0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, OFS_CELL_CFG, CFG0);
        apb(1'b1, OFS_CELL_CFG + 12'h004, CFG1);
        // Enable one, clear one and sync clear come from local routing
        apb(1'b1, OFS_CTRL_SRC, 32'h00fbefb8);
        apb(1'b0, OFS_CELL_CFG, '0);
        chk("cell cfg", CFG0, rd);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) cell_data[7:0] <= {i[3:0], i[3:0]};
            @(negedge clk);
            chk("and table", {31'h0, i == 15}, {31'h0, route_out_a[0]});
            chk("xor table", {31'h0, ^i[3:0]}, {31'h0, route_out_a[1]});
        end
        $display("test tables done");
        tick();
        chk("register out", 32'h1, {31'h0, local_out[0]});
        chk("table out", 32'h1, {31'h0, route_out_a[0]});
        @(posedge clk) cell_data[3:0] <= 4'h0;
        @(negedge clk);
        chk("table follows", 32'h0, {31'h0, route_out_a[0]});
        chk("register holds", 32'h1, {31'h0, local_out[0]});
        @(posedge clk) local_ctrl[2] <= 1'b0;
        tick();
        chk("enable low", 32'h1, {31'h0, local_out[0]});
        @(posedge clk) local_ctrl[2] <= 1'b1;
        tick();
        chk("enable high", 32'h0, {31'h0, local_out[0]});
        $display("test clocking done");
        @(posedge clk) cell_data[3:0] <= 4'hf;
        tick();
        @(posedge clk) local_ctrl[6] <= 1'b1;
        tick();
        chk("sync clear", 32'h0, {31'h0, local_out[0]});
        @(posedge clk) local_ctrl[6] <= 1'b0;
        tick();
        @(posedge clk) local_ctrl[4] <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk("async clear", 32'h0, {31'h0, local_out[0]});
        @(posedge clk) local_ctrl[4] <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk("clear stored", 32'h0, {31'h0, local_out[0]});
        tick();
        @(posedge clk) device_wide_reset_n <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk("device reset", 32'h0, {31'h0, local_out[0]});
        @(posedge clk) device_wide_reset_n <= 1'b1;
        $display("test clears done");
        // Chain every cell and shift a one from the chain input to the end
        apb(1'b1, OFS_CELL_CFG, 32'h08508000);
        for (int i = 1; i < 16; i++) begin
            apb(1'b1, OFS_CELL_CFG + 12'(4 * i), 32'h08000000);
        end
        @(posedge clk) chain_in <= 1'b1;
        repeat (15) tick();
        chk("chain after 15", 32'h0, 32'(chain_out));
        tick();
        chk("chain after 16", 32'h1, 32'(chain_out));
        $display("test chain done");
        // Carry passes idle cells, then cell 1 adds a=1, b=0 and carry in
        @(posedge clk) carry_in <= 1'b1;
        @(negedge clk);
        chk("carry through", 32'h1, 32'(carry_out));
        apb(1'b1, OFS_CELL_CFG + 12'h004, 32'h02086996);
        @(posedge clk) cell_data[7:4] <= 4'h1;
        carry_in <= 1'b0;
        @(negedge clk);
        chk("sum no carry", 32'h1, 32'(route_out_a[1]));
        chk("carry none", 32'h0, 32'(carry_out));
        @(posedge clk) carry_in <= 1'b1;
        @(negedge clk);
        chk("sum with carry", 32'h0, 32'(route_out_a[1]));
        chk("carry out", 32'h1, 32'(carry_out));
        $display("test carry done");
        // Packed toggle cell 0 ignores the sync load; cell 1 takes it
        apb(1'b1, OFS_CELL_CFG, 32'h10518000);
        apb(1'b1, OFS_CTRL_SRC, 32'h00dbef80);
        apb(1'b1, OFS_CTRL_MODE, 32'h00000006);
        @(posedge clk) cell_data[7:4] <= 4'h9;
        local_ctrl[7] <= 1'b1;
        tick();
        chk("packed no load", 32'h0, 32'(local_out[0]));
        chk("sync load", 32'h1, 32'(route_out_b[1]));
        apb(1'b0, OFS_STATUS, '0);
        chk("status", 32'h1a, {27'h0, rd[18:16], rd[1:0]});
        @(posedge clk) local_ctrl[6] <= 1'b1;
        tick();
        chk("clear over load", 32'h0, 32'(route_out_b[1]));
        chk("clear packed", 32'h0, 32'(local_out[0]));
        // A whole row clock pulse while frozen must leave no event behind
        @(posedge clk) local_ctrl[7:6] <= 2'b00;
        ce <= 1'b0;
        tick();
        @(posedge clk) ce <= 1'b1;
        @(negedge clk);
        chk("frozen", 32'h0, 32'(local_out[0]));
        tick();
        chk("toggle", 32'h1, 32'(local_out[0]));
        $display("test modes done");
        final_report();
    end
endmodule : test_logic_cell_cluster
